// [hw/pwmdf_cfg.svh]
// Register map, field positions, reset values and timing figures of the PWM block.
// Assumes inclusion by the package and the top module only.
`ifndef PWMDF_CFG_SVH
`define PWMDF_CFG_SVH
`define PWMDF_OFS_ON        12'h000
`define PWMDF_OFS_OFF       12'h004
`define PWMDF_OFS_CFG       12'h008
`define PWMDF_BIT_EN        0
`define PWMDF_BIT_CLKSEL    1
`define PWMDF_BIT_INV       2
`define PWMDF_DIV_LSB       3
`define PWMDF_DIV_MSB       6
`define PWMDF_RST_ON        16'h0000
`define PWMDF_RST_OFF       16'hFFFF
`define PWMDF_RST_CFG       7'h00
`define PWMDF_FAST_HZ       48000000
`define PWMDF_SLOW_HZ       100000
`define PWMDF_SYS_HZ        20000000
`endif

// [hw/pwmdf_pkg.sv]
// Types shared by the PWM block.
// Assumes the configuration header sits beside it.
`include "pwmdf_cfg.svh"
package pwmdf_pkg;
    typedef enum logic [2:0] {
        PWMDF_IDLE = 3'b001,
        PWMDF_HIGH = 3'b010,
        PWMDF_LOW  = 3'b100
    } pwmdf_state_e;

    typedef struct packed {
        logic [3:0] div;
        logic       invert;
        logic       clk_sel;
        logic       enable;
    } pwmdf_cfg_s;
endpackage

// [hw/pwmdf_top.sv]
// PWM generator with APB register access, byte-complete holding registers and sleep.
// Assumes APB master on sys_clk; clock sources arrive as pins and are sampled.
//
// Functional notes
// R1: Accept fast and slow counter clock sources
// R2: Select source by bit 1, prescale bits 6:3
// R3: Period is (div+1) times both phases plus one
// R4: Duty is on phase plus one over sum
// R5: High count n gives n+1 on ticks
// R6: High zero, low nonzero holds output off
// R7: Output toggles, stays high or stays low
// R8: Toggle alternates with programmed phase lengths
// R9: Sleep clears counters and forces output off
// R10: System reset restores every default
// R11: No interrupt or event output exists
// R12: Software accesses counts as 16-bit quantities
// R13: Count writes land in holding registers
// R14: Copy holding after four bytes and off end
// R15: Full-on copies as soon as bytes complete
// R16: Transfer empties holding, needs four new bytes
// R17: Count reads return active values only
// R18: Registers decoded at 00h, 04h and 08h
// R19: High count reset 0000h, upper half reserved
// R20: Select one means slow, zero means fast
// R21: Low count n gives n+1; zero full on
// R22: Disable resets counters, state, inactive output
// R23: Polarity bit 2 makes on level low
// R24: Counter loads phase count, switches at zero
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "pwmdf_cfg.svh"
module pwmdf_top
    import pwmdf_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              power_clock_reset_ctrl_sleep,
    input  wire logic              fast_clock_source,
    input  wire logic              slow_clock_source,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   pwm_out_signal
);

initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
        $error("ADDR_W out of range");
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reset release

logic [1:0] rst_sync_r;
logic       rst_n;

always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        rst_sync_r <= 2'h0;
    end else begin
        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
end

assign rst_n = rst_sync_r[1];

////////////////////////////////////////////////////////////////////////////////
// Clock source sampling

logic [2:0] fast_s_r;
logic [2:0] slow_s_r;
logic       fast_lvl_r;
logic       slow_lvl_r;
logic       fast_edge;
logic       slow_edge;

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        fast_s_r   <= 3'h0;
        slow_s_r   <= 3'h0;
        fast_lvl_r <= 1'b0;
        slow_lvl_r <= 1'b0;
    end else begin
        fast_s_r <= {fast_s_r[1:0], fast_clock_source}; // [R1]
        slow_s_r <= {slow_s_r[1:0], slow_clock_source}; // [R1]
        if (fast_s_r[1] == fast_s_r[2]) begin
            fast_lvl_r <= fast_s_r[2];
        end
        if (slow_s_r[1] == slow_s_r[2]) begin
            slow_lvl_r <= slow_s_r[2];
        end
    end
end

assign fast_edge = (fast_s_r[1] == fast_s_r[2]) && fast_s_r[2] && !fast_lvl_r;
assign slow_edge = (slow_s_r[1] == slow_s_r[2]) && slow_s_r[2] && !slow_lvl_r;

////////////////////////////////////////////////////////////////////////////////
// APB slave

pwmdf_cfg_s cfg_r;
logic [15:0] on_act_r;
logic [15:0] off_act_r;
logic [ADDR_W-1:0] ofs;
logic        acc;
logic        wr_en;
logic        hit_on;
logic        hit_off;
logic        hit_cfg;
logic        addr_err;
logic [31:0] rd_mux;

assign ofs      = paddr;
assign hit_on   = (ofs == ADDR_W'(`PWMDF_OFS_ON)); // [R18]
assign hit_off  = (ofs == ADDR_W'(`PWMDF_OFS_OFF));
assign hit_cfg  = (ofs == ADDR_W'(`PWMDF_OFS_CFG));
assign addr_err = !(hit_on || hit_off || hit_cfg);
assign acc      = psel && penable && pready;
assign wr_en    = acc && pwrite && !pslverr;

always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_on) begin
        rd_mux = {16'h0000, on_act_r}; // [R17] [R19]
    end else if (hit_off) begin
        rd_mux = {16'h0000, off_act_r}; // [R17]
    end else if (hit_cfg) begin
        rd_mux = {25'h000_0000, cfg_r};
    end
end

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        pready <= psel && penable && !pready;
        if (psel && penable && !pready) begin
            pslverr <= addr_err;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pslverr <= 1'b0;
        end
    end
end

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        cfg_r <= `PWMDF_RST_CFG; // [R10]
    end else if (wr_en && hit_cfg && pstrb[0]) begin
        cfg_r <= pwdata[`PWMDF_DIV_MSB:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Holding registers

logic [7:0] hold_r [4];
logic       vld_r  [4];
logic       all4;
logic       xfer;

genvar gi;
generate
    for (gi = 0; gi < 4; gi++) begin : g_hold
        logic hit_b;
        assign hit_b = wr_en && pstrb[gi % 2] && ((gi < 2) ? hit_on : hit_off);
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                hold_r[gi] <= 8'h00;
                vld_r[gi]  <= 1'b0;
            end else begin
                if (hit_b) begin
                    hold_r[gi] <= pwdata[(gi % 2) * 8 +: 8]; // [R13]
                    vld_r[gi]  <= 1'b1;
                end else if (xfer) begin
                    vld_r[gi]  <= 1'b0; // [R16]
                end
            end
        end
    end
endgenerate

assign all4 = vld_r[0] && vld_r[1] && vld_r[2] && vld_r[3];

////////////////////////////////////////////////////////////////////////////////
// Active counts

logic run;
logic full_on;
logic full_off;
logic off_done;
logic [15:0] on_src;
pwmdf_state_e state_r;
logic [15:0] cnt_r;
logic tick;

assign run      = cfg_r.enable && !power_clock_reset_ctrl_sleep;
assign full_on  = (off_act_r == 16'h0000); // [R21]
assign full_off = (on_act_r == 16'h0000) && !full_on; // [R6]
assign off_done = run && (state_r == PWMDF_LOW) && tick && (cnt_r == 16'h0000);
assign xfer     = all4 && (off_done || full_on); // [R14] [R15]
assign on_src   = xfer ? {hold_r[1], hold_r[0]} : on_act_r;

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        on_act_r  <= `PWMDF_RST_ON; // [R19]
        off_act_r <= `PWMDF_RST_OFF;
    end else if (xfer) begin
        on_act_r  <= {hold_r[1], hold_r[0]};
        off_act_r <= {hold_r[3], hold_r[2]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Prescaler

logic [3:0] pre_r;
logic       src_edge;

assign src_edge = cfg_r.clk_sel ? slow_edge : fast_edge; // [R2] [R20]
assign tick     = src_edge && (pre_r >= cfg_r.div);

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        pre_r <= 4'h0;
    end else if (!run) begin
        pre_r <= 4'h0; // [R9] [R22]
    end else if (src_edge) begin
        pre_r <= tick ? 4'h0 : pre_r + 4'h1; // [R3]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Phase counter

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= PWMDF_IDLE;
        cnt_r   <= 16'h0000;
    end else if (!run) begin
        state_r <= PWMDF_IDLE; // [R9] [R22]
        cnt_r   <= 16'h0000;
    end else begin
        case (state_r)
            PWMDF_IDLE: begin
                state_r <= PWMDF_HIGH;
                cnt_r   <= on_src; // [R24]
            end
            PWMDF_HIGH: begin
                if (tick) begin
                    if (cnt_r == 16'h0000) begin
                        state_r <= PWMDF_LOW; // [R5] [R8]
                        cnt_r   <= off_act_r; // [R21] [R24]
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
            end
            PWMDF_LOW: begin
                if (tick) begin
                    if (cnt_r == 16'h0000) begin
                        state_r <= PWMDF_HIGH; // [R3] [R4]
                        cnt_r   <= on_src;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
            end
            default: begin
                state_r <= PWMDF_IDLE;
                cnt_r   <= 16'h0000;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output, the only driven pin besides the bus; no event line exists [R11]

logic pwm_on;

assign pwm_on = run && (full_on || (!full_off && state_r == PWMDF_HIGH)); // [R7]

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        pwm_out_signal <= 1'b0;
    end else begin
        pwm_out_signal <= pwm_on ^ cfg_r.invert; // [R23]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Assertions

default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);

a_sleep_clears: assert property ( // [R9]
    power_clock_reset_ctrl_sleep |=> state_r == PWMDF_IDLE && cnt_r == 16'h0000
        && pre_r == 4'h0 && pwm_out_signal == $past(cfg_r.invert))
    else $error("sleep did not clear the counter");

a_disable_idle: assert property ( // [R22]
    !cfg_r.enable ##1 !cfg_r.enable |-> state_r == PWMDF_IDLE
        && pwm_out_signal == $past(cfg_r.invert))
    else $error("disabled block not idle");

a_full_off_low: assert property ( // [R6]
    run && full_off |=> pwm_out_signal == $past(cfg_r.invert))
    else $error("full off output active");

a_full_on_high: assert property ( // [R21]
    run && full_on |=> pwm_out_signal != $past(cfg_r.invert))
    else $error("full on output inactive");

a_xfer_cause: assert property ( // [R14]
    $changed(on_act_r) || $changed(off_act_r) |-> $past(all4)
        && ($past(off_done) || $past(full_on)))
    else $error("active counts changed without complete holding");

a_hold_empty: assert property ( // [R16]
    xfer && !wr_en |=> !vld_r[0] && !vld_r[1] && !vld_r[2] && !vld_r[3])
    else $error("holding not emptied after transfer");

a_read_active: assert property ( // [R17]
    psel && penable && !pready && !pwrite && hit_on
        |=> pready && prdata == {16'h0000, $past(on_act_r)})
    else $error("on count read not active value");

a_phase_switch: assert property ( // [R5]
    state_r == PWMDF_HIGH && $past(state_r) == PWMDF_HIGH && run
        ##1 state_r == PWMDF_LOW |-> $past(tick) && $past(cnt_r) == 16'h0000)
    else $error("phase switched before count end");

a_tick_period: assert property ( // [R3]
    run && !src_edge |=> pre_r == $past(pre_r))
    else $error("prescaler moved without source edge");

a_prescale_wrap: assert property ( // [R3]
    run && tick |=> pre_r == 4'h0)
    else $error("prescaler not restarted after tick");

a_off_load: assert property ( // [R24]
    run && state_r == PWMDF_HIGH && tick && cnt_r == 16'h0000 |=> cnt_r == $past(off_act_r))
    else $error("off phase not loaded from active count");

a_full_on_xfer: assert property ( // [R15]
    full_on && all4 |=> on_act_r == {$past(hold_r[1]), $past(hold_r[0])})
    else $error("full on did not take holding at once");

a_unmapped_err: assert property ( // [R18]
    psel && penable && !pready && addr_err |=> pready && pslverr)
    else $error("unmapped access not refused");

c_toggle: cover property (
    state_r == PWMDF_HIGH ##1 state_r == PWMDF_LOW ##[1:1000] state_r == PWMDF_HIGH);

c_off_xfer: cover property (off_done && all4);

c_fullon_xfer: cover property (full_on && all4 && run);

c_sleep: cover property (run && state_r == PWMDF_LOW ##1 power_clock_reset_ctrl_sleep);

endmodule

// [testbench/pwmdf_load.sv]
// Load model: measures the high and low run lengths seen on the PWM pin.
// Assumes the pin is a level sampled on sys_clk.
`timescale 1ns/10ps
module pwmdf_load (
    input  wire logic        sys_clk,
    input  wire logic        pwm_in,
    output logic      [32:0] high_len,
    output logic      [32:0] low_len
);
    logic        last_r = 1'b0;
    logic [32:0] run_r  = 33'h0;
    logic [32:0] high_r = 33'h0;
    logic [32:0] low_r  = 33'h0;
    assign high_len = high_r;
    assign low_len  = low_r;
    ////////////////////////////////////////////////////////////////////////
    // Run length in sys_clk cycles, latched at each level change
    always @(posedge sys_clk) begin
        last_r <= pwm_in;
        run_r <= (pwm_in != last_r) ? 33'h1 : run_r + 33'h1;
        if (pwm_in != last_r && last_r) high_r <= run_r;
        if (pwm_in != last_r && !last_r) low_r <= run_r;
    end
endmodule

// [testbench/pwmdf_top_tb.sv]
// Testbench of the PWM block: APB master, source pins, load model, checks.
// Assumes slow source period 8 and fast source period 16 sys_clk cycles.
`timescale 1ns/10ps
module pwmdf_top_tb;
    import pwmdf_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0, sleep = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv, seed = 32'h63;
    logic [3:0]  pstrb = 4'h0, fdiv = 4'h0, dv;
    logic [2:0]  sdiv = 3'h0;
    logic        pready, pslverr, pwm, re, inv, sel;
    logic [32:0] hi, lo;
    logic [15:0] on_v, off_v;
    int          errors = 0, total_checks = 0, cyc = 0, p;
    ////////////////////////////////////////////////////////////////////////
    // Clock, source pins, design and load
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        sdiv <= sdiv + 3'h1;
        fdiv <= fdiv + 4'h1;
    end
    pwmdf_top i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .power_clock_reset_ctrl_sleep(sleep),
        .fast_clock_source(fdiv[3]), .slow_clock_source(sdiv[2]),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out_signal(pwm));
    pwmdf_load i_load (.sys_clk(sys_clk), .pwm_in(pwm), .high_len(hi), .low_len(lo));
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] cfgw(logic [3:0] d, logic i, logic s, logic e);
        pwmdf_cfg_s c;
        c = '{d, i, s, e};
        return {25'h0, c};
    endfunction
    function automatic int plen(logic [15:0] n, logic [3:0] d, int per);
        return (int'(n) + 1) * (int'(d) + 1) * per;
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h3, rv, re);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [32:0] exp);
        apb(1'b0, a, 32'h0, 4'h0, rv, re);
        chk({re, rv}, exp);
    endtask
    task automatic await_on(input logic [15:0] v);
        do apb(1'b0, 12'h000, 32'h0, 4'h0, rv, re);
        while (rv[15:0] !== v);
    endtask
    task automatic hold(input logic lvl, input int n);
        int bad;
        bad = 0;
        repeat (3) @(posedge sys_clk);
        repeat (n) begin
            @(posedge sys_clk);
            if (pwm !== lvl) bad++;
        end
        chk(33'(bad), 33'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 900000) begin
            errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc(12'h000, 33'h0);
        rdc(12'h004, 33'h0FFFF);
        rdc(12'h008, 33'h0);
        rdc(12'h00C, {1'b1, 32'h0});
        wr(12'h008, cfgw(4'h0, 1'b0, 1'b1, 1'b1));
        hold(1'b0, 300);
        wr(12'h000, 32'hFFFF0001);
        wr(12'h004, 32'h00000002);
        rdc(12'h000, 33'h0);
        await_on(16'h0001);
        rdc(12'h000, 33'h1);
        rdc(12'h004, 33'h2);
        for (int k = 1; k < 5; k++) begin
            seed = xs(seed);
            dv = seed[3:0];
            inv = (k == 2) ? 1'b1 : ((k == 1) ? 1'b0 : seed[4]);
            sel = (k != 3);
            p = sel ? 8 : 16;
            on_v = 16'(k * 4 + 1) + 16'(seed[6:5]);
            off_v = 16'h1 + 16'(seed[9:7]);
            wr(12'h008, cfgw(dv, inv, sel, 1'b1));
            wr(12'h000, {16'h0, on_v});
            wr(12'h004, {16'h0, off_v});
            await_on(on_v);
            rdc(12'h004, {17'h0, off_v});
            repeat (3 * plen(on_v + off_v + 16'h1, dv, p) + 40) @(posedge sys_clk);
            chk(hi, 33'(plen(inv ? off_v : on_v, dv, p)));
            chk(lo, 33'(plen(inv ? on_v : off_v, dv, p)));
        end
        wr(12'h008, cfgw(4'h0, 1'b0, 1'b1, 1'b1));
        wr(12'h000, 32'h7);
        repeat (3 * plen(16'h30, 4'h0, 8)) @(posedge sys_clk);
        rdc(12'h000, {17'h0, on_v});
        wr(12'h004, 32'h0);
        await_on(16'h0007);
        rdc(12'h004, 33'h0);
        hold(1'b1, 300);
        wr(12'h000, 32'h3);
        wr(12'h004, 32'h4);
        rdc(12'h000, 33'h3);
        rdc(12'h004, 33'h4);
        wr(12'h008, cfgw(4'h0, 1'b1, 1'b1, 1'b0));
        hold(1'b1, 200);
        rdc(12'h000, 33'h3);
        wr(12'h008, cfgw(4'h0, 1'b0, 1'b1, 1'b1));
        sleep <= 1'b1;
        hold(1'b0, 200);
        sleep <= 1'b0;
        complete_run();
    end
endmodule
